// File: design/crossbar_output_routing.sv
// crossbar output multiplexers, select registers and converter limit to pwm path
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`include "xbar_params.svh"
//Contract
// - outputs 0..5 drive six package pins
// - outputs 6,7,8 trigger converters and dac
// - outputs 9..11 drive comparator windows
// - outputs 12..15 drive pwm alternate controls
// - outputs 16..19 drive pwm external syncs
// - output 20 drives pwm external clock
// - outputs 21..24 drive pwm faults 0..3
// - output 25 drives pwm output force
// - outputs 26..29 feed timer when selected
// - slot 0..2 limit results drive pwm limits
// - pwm submodule 3 limit input stays low
// - result above high limit drives low
// - result below low limit drives high
// - thirty muxes each pick one of 22
// - input to output path purely combinational
// - select registers are write protected
module crossbar_output_routing
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // avalon-mm slave
    input  wire logic [7:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [3:0]              byteenable,
    input  wire logic [31:0]             writedata,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    // shared crossbar sources
    input  wire logic [`XB_NUM_IN-1:0]   crossbar_input_n,
    // converter result slots with limits
    input  wire xbar_pkg::slot_limit_s   result_slot [`XB_NUM_SLOT],
    // routed destinations
    output wire logic [5:0]              crossbar_pin_output,
    output wire logic                    converter_a_trigger,
    output wire logic                    converter_b_trigger,
    output wire logic                    dac_sync_in,
    output wire logic [2:0]              comparator_window,
    output wire xbar_pkg::pwm_xbar_s     pwm_xbar,
    output wire logic [3:0]              timer_b_channel,
    // limit controls of pwm submodules 0..3
    output logic      [3:0]              pwm_limit_control_in
);

    // select registers, one per crossbar output
    xbar_pkg::xbar_sel_t       sel      [`XB_NUM_OUT];
    xbar_pkg::xbar_sel_t       next_sel [`XB_NUM_OUT];
    logic [3:0]                tsel;              // timer input select bits
    logic [3:0]                next_tsel;
    logic [1:0]                wr_protect;        // protect enable and lock
    logic [1:0]                next_wr_protect;
    logic                      next_waitreq;
    logic [31:0]               next_readdata;
    logic [3:0]                next_limit;
    logic [31:0]               rd_word;           // decoded read value
    logic [`XB_NUM_IN-1:0]     src;               // sources after fixed inputs
    logic [`XB_NUM_OUT-1:0]    xbar_out;          // raw multiplexer outputs
    logic                      accept_wr;         // write taking effect now
    logic                      sel_hit;           // address is a select register
    logic [4:0]                sel_idx;           // word index of the access
    logic                      protect_en;        // select writes blocked

    assign sel_idx   = address[6:2];
    assign sel_hit   = (address[7] == 1'b0) && (sel_idx < 5'(`XB_NUM_OUT));
    assign accept_wr = write && !waitrequest;
    assign protect_en = wr_protect[`XB_PROTECT_EN_BIT];

    // fixed sources: zero, one and the unused slot reads as zero
    assign src = {crossbar_input_n[`XB_NUM_IN-1:`XB_IN_UNUSED+1], 1'b0,
                  crossbar_input_n[`XB_IN_UNUSED-1:`XB_IN_ONE+1], 1'b1, 1'b0};

    // thirty identical muxes; no flop in the path so a pwm fault is not delayed
    generate
        for (genvar i = 0; i < `XB_NUM_OUT; i++)
        begin : g_mux
            // an out-of-range select yields zero instead of an unknown
            assign xbar_out[i] = (sel[i] < 5'(`XB_NUM_IN)) ? src[sel[i]] : 1'b0;
        end
    endgenerate

    // destination wiring
    assign crossbar_pin_output   = xbar_out[`XB_OUT_PIN +: 6];
    assign converter_a_trigger   = xbar_out[`XB_OUT_CONV_A];
    assign converter_b_trigger   = xbar_out[`XB_OUT_CONV_B];
    assign dac_sync_in           = xbar_out[`XB_OUT_DAC];
    assign comparator_window     = xbar_out[`XB_OUT_CMP +: 3];
    assign pwm_xbar.alt_control  = xbar_out[`XB_OUT_ALT +: 4];
    assign pwm_xbar.pwm_external_sync_in     = xbar_out[`XB_OUT_SYNC +: 4];
    assign pwm_xbar.ext_clock    = xbar_out[`XB_OUT_CLK];
    assign pwm_xbar.fault        = xbar_out[`XB_OUT_FAULT +: 4];
    assign pwm_xbar.force_out    = xbar_out[`XB_OUT_FORCE];
    // timer channels see zero while their select bit is clear
    assign timer_b_channel       = xbar_out[`XB_OUT_TMR +: 4] & tsel;

    // read decode; unmapped words read zero
    always_comb
    begin
        rd_word = 32'h0;
        if (sel_hit)
        begin
            rd_word[`XB_SEL_W-1:0] = sel[sel_idx];
        end
        else if (address == `XB_OFS_TSEL)
        begin
            rd_word[`XB_TSEL_LSB +: 4] = tsel;
        end
        else if (address == `XB_OFS_PROTECT)
        begin
            rd_word[1:0] = wr_protect;
        end
        else if (address == `XB_OFS_STAT)
        begin
            rd_word[3:0] = pwm_limit_control_in;   // live limit levels
        end
    end

    // bus handshake: one wait cycle, answer in the next
    always_comb
    begin
        next_waitreq  = 1'b1;
        next_readdata = readdata;
        if ((read || write) && waitrequest)
        begin
            next_waitreq  = 1'b0;
            next_readdata = read ? rd_word : 32'h0;
        end
    end

    // bus flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end
        else
        begin
            waitrequest <= next_waitreq;
            readdata    <= next_readdata;
        end
    end

    // configuration next values
    always_comb
    begin
        for (int i = 0; i < `XB_NUM_OUT; i++)
        begin
            next_sel[i] = sel[i];
        end
        next_tsel = tsel;
        next_wr_protect = wr_protect;
        // protected select writes are dropped silently
        if (accept_wr && sel_hit && byteenable[0] && !protect_en)
        begin
            next_sel[sel_idx] = writedata[`XB_SEL_W-1:0];
        end
        if (accept_wr && (address == `XB_OFS_TSEL) && byteenable[1])
        begin
            next_tsel = writedata[`XB_TSEL_LSB +: 4];
        end
        // lock freezes the protection setting until reset
        if (accept_wr && (address == `XB_OFS_PROTECT) && byteenable[0]
            && !wr_protect[`XB_PROTECT_LOCK_BIT])
        begin
            next_wr_protect = writedata[1:0];
        end
    end

    // configuration flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `XB_NUM_OUT; i++)
            begin
                sel[i] <= `XB_SEL_RST;
            end
            tsel <= `XB_TSEL_RST;
            wr_protect <= `XB_PROTECT_RST;
        end
        else
        begin
            for (int i = 0; i < `XB_NUM_OUT; i++)
            begin
                sel[i] <= next_sel[i];
            end
            tsel <= next_tsel;
            wr_protect <= next_wr_protect;
        end
    end

    // limit compare per slot; high limit has priority if limits cross
    always_comb
    begin
        next_limit = pwm_limit_control_in;
        for (int s = 0; s < `XB_NUM_SLOT; s++)
        begin
            if (result_slot[s].result > result_slot[s].high_limit)
            begin
                next_limit[s] = 1'b0;
            end
            else if (result_slot[s].result < result_slot[s].low_limit)
            begin
                next_limit[s] = 1'b1;
            end
            // otherwise the previous level is kept
        end
        next_limit[3] = 1'b0;
    end

    // limit flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pwm_limit_control_in <= {4{`XB_LIMIT_RST}};
        end
        else
        begin
            pwm_limit_control_in <= next_limit;
        end
    end

    // checks
    a_pin_write_path: assert property (@(posedge clk) disable iff (!rst_n)
        (accept_wr && address == `XB_OFS_SEL_BASE && byteenable[0] && !protect_en
         && writedata[4:0] == 5'h01) |=> crossbar_pin_output[0])
        else $error("pin output 0 not high after selecting logic one");

    a_trigger_route: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_CONV_B] == 5'h01 && sel[`XB_OUT_DAC] == 5'h00)
        |-> (converter_b_trigger && !dac_sync_in))
        else $error("converter b trigger or dac sync misrouted");

    // logic zero selected must keep a converter from starting
    a_conv_a_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_CONV_A] == 5'h00) |-> !converter_a_trigger)
        else $error("converter a trigger high with logic zero selected");

    a_cmp_window: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_CMP+2] == 5'h0b) |-> (comparator_window[2] == crossbar_input_n[11]))
        else $error("comparator c window not routed");

    a_pwm_alt_sync: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_ALT+3] == 5'h02 && sel[`XB_OUT_SYNC] == 5'h00)
        |-> (pwm_xbar.alt_control[3] == crossbar_input_n[2] && !pwm_xbar.pwm_external_sync_in[0]))
        else $error("pwm alternate control or sync misrouted");

    a_pwm_clk_force: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_CLK] == 5'h01 && sel[`XB_OUT_FORCE] == 5'h15)
        |-> (pwm_xbar.ext_clock && pwm_xbar.force_out == crossbar_input_n[21]))
        else $error("pwm clock or force misrouted");

    a_pwm_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[`XB_OUT_FAULT+3] == 5'h09 && $changed(crossbar_input_n[9]))
        |-> (pwm_xbar.fault[3] == crossbar_input_n[9]))
        else $error("fault 3 lags or misses its source");

    a_timer_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !tsel[0] |-> !timer_b_channel[0])
        else $error("timer channel 0 driven while not selected");

    a_timer_pass: assert property (@(posedge clk) disable iff (!rst_n)
        (tsel[3] && sel[`XB_OUT_TMR+3] == 5'h01) |-> timer_b_channel[3])
        else $error("timer channel 3 blocked while selected");

    a_mux_range: assert property (@(posedge clk) disable iff (!rst_n)
        (sel[0] >= 5'h16) |-> !crossbar_pin_output[0])
        else $error("out-of-range select not zero");

    a_protect_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (accept_wr && sel_hit && sel_idx == 5'h05 && protect_en) |=> $stable(sel[5]))
        else $error("protected select register changed");

    a_limit_high: assert property (@(posedge clk) disable iff (!rst_n)
        (result_slot[1].result > result_slot[1].high_limit) |=> !pwm_limit_control_in[1])
        else $error("slot 1 above high limit but limit input not low");

    a_limit_low: assert property (@(posedge clk) disable iff (!rst_n)
        (result_slot[2].result < result_slot[2].low_limit
         && result_slot[2].result <= result_slot[2].high_limit)
        |=> pwm_limit_control_in[2])
        else $error("slot 2 below low limit but limit input not high");

    a_limit_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (result_slot[0].result <= result_slot[0].high_limit
         && result_slot[0].result >= result_slot[0].low_limit)
        |=> $stable(pwm_limit_control_in[0]))
        else $error("slot 0 level moved while inside limits");

    a_slot3_low: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 !pwm_limit_control_in[3])
        else $error("submodule 3 limit input not low");

endmodule

// File: design/xbar_params.svh
// constants of the crossbar output side: offsets, field positions, reset values, indices
`ifndef XBAR_PARAMS_SVH
`define XBAR_PARAMS_SVH
// sizes
`define XB_NUM_OUT       30
`define XB_NUM_IN        22
`define XB_SEL_W         5
`define XB_NUM_SLOT      3
`define XB_RES_W         12
// register byte offsets; select register i sits at XB_OFS_SEL_BASE + 4*i
`define XB_OFS_SEL_BASE  8'h00
`define XB_OFS_TSEL      8'h80
`define XB_OFS_PROTECT   8'h84
`define XB_OFS_STAT      8'h88
// field positions
`define XB_TSEL_LSB      12
`define XB_PROTECT_EN_BIT   0
`define XB_PROTECT_LOCK_BIT 1
// reset values
`define XB_SEL_RST       5'h00
`define XB_TSEL_RST      4'h0
`define XB_PROTECT_RST   2'h0
`define XB_LIMIT_RST     1'b0
// crossbar output indices
`define XB_OUT_PIN       0
`define XB_OUT_CONV_A    6
`define XB_OUT_CONV_B    7
`define XB_OUT_DAC       8
`define XB_OUT_CMP       9
`define XB_OUT_ALT       12
`define XB_OUT_SYNC      16
`define XB_OUT_CLK       20
`define XB_OUT_FAULT     21
`define XB_OUT_FORCE     25
`define XB_OUT_TMR       26
// crossbar input indices with fixed meaning
`define XB_IN_ZERO       0
`define XB_IN_ONE        1
`define XB_IN_UNUSED     8
`endif

// File: design/xbar_pkg.sv
// types shared by the crossbar output side
package xbar_pkg;
`include "xbar_params.svh"
    // every pwm input fed by the crossbar
    typedef struct packed {
        logic [3:0] alt_control;   // per-submodule alternate control
        logic [3:0] pwm_external_sync_in;      // per-submodule external sync
        logic       ext_clock;     // module-wide external clock
        logic [3:0] fault;         // fault 0..3
        logic       force_out;     // external output force
    } pwm_xbar_s;
    // one converter result slot with its limits
    typedef struct packed {
        logic [`XB_RES_W-1:0] result;
        logic [`XB_RES_W-1:0] high_limit;
        logic [`XB_RES_W-1:0] low_limit;
    } slot_limit_s;
    typedef logic [`XB_SEL_W-1:0] xbar_sel_t;
endpackage

// File: tb/crossbar_output_routing_bench.sv
// self-checking bench for the crossbar output side
`timescale 1ns/1ns
`include "xbar_params.svh"
module crossbar_output_routing_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        go = 1'b0;
    logic [21:0] src;
    xbar_pkg::slot_limit_s slot [`XB_NUM_SLOT];
    logic [5:0]  pins;
    logic        cta;
    logic        ctb;
    logic        dac;
    logic [2:0]  cmp_w;
    xbar_pkg::pwm_xbar_s pwm;
    logic [3:0]  tmr;
    logic [3:0]  lim;
    logic [29:0] outv;
    // shadow of the registers and the limit levels
    logic [4:0]  sel [30] = '{default: 5'h00};
    logic [3:0]  tsel = 4'h0;
    logic [1:0]  wr_protect = 2'h0;
    logic [3:0]  elim = 4'h0;
    logic [4:0]  corner [6] = '{5'h01, 5'h00, 5'h08, 5'h15, 5'h16, 5'h1f};
    // fixed output/select pairs so every routing assertion sees its case
    logic [4:0]  hand_out [11] = '{5'd0, 5'd6, 5'd7, 5'd8, 5'd11, 5'd15, 5'd16, 5'd20,
                                   5'd24, 5'd25, 5'd29};
    logic [4:0]  hand_sel [11] = '{5'h16, 5'h00, 5'h01, 5'h00, 5'h0b, 5'h02, 5'h00, 5'h01,
                                   5'h09, 5'h15, 5'h01};
    logic [29:0] eout;
    logic        chk = 1'b0;
    logic [31:0] rd;
    logic [7:0]  a;
    int          fail_count = 0;
    int          n_compared = 0;
    assign outv = {tmr, pwm.force_out, pwm.fault, pwm.ext_clock, pwm.pwm_external_sync_in,
                   pwm.alt_control, cmp_w, dac, ctb, cta, pins};
    far_side_model far_side_model_i (.clk(clk), .go(go), .crossbar_input_n(src),
                                     .result_slot(slot));
    crossbar_output_routing crossbar_output_routing_i (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .crossbar_input_n(src), .result_slot(slot), .crossbar_pin_output(pins),
        .converter_a_trigger(cta), .converter_b_trigger(ctb), .dac_sync_in(dac),
        .comparator_window(cmp_w), .pwm_xbar(pwm), .timer_b_channel(tmr),
        .pwm_limit_control_in(lim));
    initial forever #5 clk = ~clk;
    // verdict in one place
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one avalon access; shadow follows only writes the block must accept
    task automatic bus(input logic rw, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        address <= ad;
        writedata <= d;
        byteenable <= be;
        read <= rw;
        write <= !rw;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 50)
            cmp(32'h0, 32'h1, "no answer");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (!rw && ad < 8'h78 && be[0] && !wr_protect[0]) sel[ad[6:2]] = d[4:0];
        if (!rw && ad == `XB_OFS_TSEL && be[1]) tsel = d[15:12];
        if (!rw && ad == `XB_OFS_PROTECT && be[0] && !wr_protect[1]) wr_protect = d[1:0];
        @(posedge clk);
    endtask
    function automatic logic [31:0] exp_reg(input logic [7:0] ad);
        if (ad < 8'h78) return {27'h0, sel[ad[6:2]]};
        if (ad == `XB_OFS_TSEL) return {16'h0, tsel, 12'h000};
        if (ad == `XB_OFS_PROTECT) return {30'h0, wr_protect};
        if (ad == `XB_OFS_STAT) return {28'h0, elim};
        return 32'h0;
    endfunction
    task automatic check_rd(input logic [7:0] ad);
        bus(1'b1, ad, 32'h0, 4'hf);
        cmp(rd, exp_reg(ad), "readback");
    endtask
    // zero, one and the unused source are fixed; timer outputs gated
    function automatic logic [29:0] exp_route();
        logic [29:0] r;
        for (int i = 0; i < 30; i++)
            r[i] = sel[i] == 5'h01 || (sel[i] < 5'h16 && sel[i] != 5'h08 && sel[i] != 5'h00
                   && src[sel[i]]);
        return {r[29:26] & tsel, r[25:0]};
    endfunction
    // limit levels: above high drives low, below low drives high, else held
    always @(posedge clk)
    begin
        if (!rst_n)
            elim <= 4'h0;
        else
            for (int s = 0; s < 3; s++)
                if (slot[s].result > slot[s].high_limit) elim[s] <= 1'b0;
                else if (slot[s].result < slot[s].low_limit) elim[s] <= 1'b1;
    end
    // combinational outputs checked mid-cycle, where settled
    always @(negedge clk)
    begin
        if (chk)
        begin
            eout = exp_route();
            cmp(32'(outv[11:0]), 32'(eout[11:0]), "route");
            cmp(32'(outv[29:12]), 32'(eout[29:12]), "pwm");
            cmp({28'h0, lim}, {28'h0, elim}, "limit");
        end
    end
    initial
    begin
        void'($urandom(32'h58c5));
        repeat (2) @(posedge clk);
        chk = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        check_rd(8'h00);
        check_rd(`XB_OFS_PROTECT);
        // every output, awkward sources first
        for (int i = 0; i < 30; i++)
        begin
            bus(1'b0, 8'(4 * i), {27'h0, i < 6 ? corner[i] : 5'($urandom_range(2, 21))}, 4'hf);
            check_rd(8'(4 * i));
            repeat (3) @(posedge clk);
        end
        for (int t = 0; t < 16; t++)
        begin
            bus(1'b0, `XB_OFS_TSEL, {16'h0, 4'(t), 12'h000}, 4'h2);
            repeat (4) @(posedge clk);
        end
        check_rd(`XB_OFS_TSEL);
        bus(1'b0, 8'h00, 32'h3, 4'he);
        check_rd(8'h00);
        // hand-written selects, then let the random sources toggle under them
        for (int h = 0; h < 11; h++)
        begin
            bus(1'b0, {1'b0, hand_out[h], 2'b00}, {27'h0, hand_sel[h]}, 4'hf);
        end
        repeat (40) @(posedge clk);
        // random writes and reads, holes included
        repeat (60)
        begin
            bus(1'b0, 8'($urandom_range(0, 29) * 4), $urandom, 4'hf);
            a = 8'($urandom_range(0, 63) * 4);
            check_rd(a == `XB_OFS_STAT ? 8'h8c : a);
        end
        go <= 1'b0;
        repeat (3) @(posedge clk);
        check_rd(`XB_OFS_STAT);
        go <= 1'b1;
        // protection on, off, then locked
        bus(1'b0, `XB_OFS_PROTECT, 32'h1, 4'hf);
        bus(1'b0, 8'h14, 32'h9, 4'hf);
        check_rd(8'h14);
        bus(1'b0, `XB_OFS_PROTECT, 32'h0, 4'hf);
        bus(1'b0, 8'h14, 32'h9, 4'hf);
        check_rd(8'h14);
        bus(1'b0, `XB_OFS_PROTECT, 32'h3, 4'hf);
        bus(1'b0, `XB_OFS_PROTECT, 32'h0, 4'hf);
        check_rd(`XB_OFS_PROTECT);
        bus(1'b0, 8'h18, 32'h2, 4'hf);
        check_rd(8'h18);
        repeat (10) @(posedge clk);
        complete_run();
    end
    // watchdog well beyond the roughly nine hundred cycles of the run
    initial
    begin
        repeat (20000) @(posedge clk);
        cmp(32'h0, 32'h1, "watchdog");
        complete_run();
    end
endmodule

// File: tb/far_side_model.sv
// far-side peripheral logic: crossbar sources and converter result slots
`timescale 1ns/1ns
`include "xbar_params.svh"
module far_side_model
(
    // clock and run control
    input  wire logic             clk,
    input  wire logic             go,
    // values handed to the block
    output logic [`XB_NUM_IN-1:0] crossbar_input_n,
    output xbar_pkg::slot_limit_s result_slot [`XB_NUM_SLOT]
);
    logic [`XB_RES_W-1:0] hi;  // drawn high limit
    logic [`XB_RES_W-1:0] lo;  // drawn low limit
    logic [`XB_RES_W-1:0] r;   // drawn result
    // known levels before the first edge
    initial
    begin
        crossbar_input_n = '0;
        for (int s = 0; s < `XB_NUM_SLOT; s++) result_slot[s] = '0;
    end
    // peripherals change only on the shared edge; go low freezes everything
    always @(posedge clk)
    begin
        if (go)
        begin
            crossbar_input_n <= `XB_NUM_IN'($urandom);
            for (int s = 0; s < `XB_NUM_SLOT; s++)
            begin
                hi = `XB_RES_W'($urandom);
                lo = `XB_RES_W'($urandom);
                // a result sitting on a limit must not trip it
                case ($urandom_range(0, 3))
                    0: r = hi;
                    1: r = lo;
                    default: r = `XB_RES_W'($urandom);
                endcase
                result_slot[s] <= '{r, hi, lo};
            end
        end
    end
endmodule
